// ---- common/lpdc_pkg.sv ----
// Types shared by the display pin control block
package lpdc_pkg;

    typedef enum logic [1:0] {
        LPDC_DUTY_STATIC = 2'h0,
        LPDC_DUTY_HALF = 2'h1,
        LPDC_DUTY_THIRD = 2'h2,
        LPDC_DUTY_QUARTER = 2'h3
    } lpdc_duty_t;

    typedef enum logic [1:0] {
        LPDC_FN_PORT = 2'h0,
        LPDC_FN_DRIVE = 2'h1,
        LPDC_FN_EXPAND = 2'h2
    } lpdc_pin_fn_t;

endpackage : lpdc_pkg

// ---- common/lpdc_regs.svh ----
// Register offsets, field positions, reset values and widths of the display pin control block
`ifndef LPDC_REGS_SVH
`define LPDC_REGS_SVH

`define LPDC_ADDR_W 12
`define LPDC_CTRL_OFS 12'h000
`define LPDC_PORT_DATA_OFS 12'h004
`define LPDC_PORT_DIR_OFS 12'h008
`define LPDC_PORT_IN_OFS 12'h00C
`define LPDC_STATUS_OFS 12'h010

`define LPDC_GROUP_LSB 0
`define LPDC_GROUP_MSB 3
`define LPDC_EXPAND_BIT 4
`define LPDC_FILL_BIT 5
`define LPDC_DUTY_LSB 6
`define LPDC_DUTY_MSB 7

`define LPDC_STAT_ILLEGAL_BIT 0
`define LPDC_STAT_EXPAND_BIT 1
`define LPDC_STAT_MASK_LSB 8
`define LPDC_STAT_BP_EN_LSB 16

`define LPDC_CTRL_RST 8'h00
`define LPDC_PORT_RST 32'h0000_0000
`define LPDC_GROUP_COUNT 8

`endif

// ---- src/lpdc_backplane_map.sv ----
// Routes backplane waveforms to the four backplane outputs by multiplex ratio and fill
`timescale 1ns/1ns
module lpdc_backplane_map
    import lpdc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire lpdc_duty_t i_duty,
    input wire logic i_fill,
    input wire logic [3:0] i_com_wave,
    input wire logic i_nonsel_wave,
    output logic [3:0] o_backplane,
    output logic [3:0] o_backplane_en
);

    logic [3:0] bp_next;
    logic [3:0] en_next;

    always_comb begin
        bp_next = 4'h0;
        en_next = 4'h0;
        unique case (i_duty)
            LPDC_DUTY_STATIC: begin
                if (i_fill) begin
                    bp_next = {4{i_com_wave[0]}};
                    en_next = 4'hF;
                end else begin
                    bp_next = {3'h0, i_com_wave[0]};
                    en_next = 4'h1;
                end
            end
            LPDC_DUTY_HALF: begin
                if (i_fill) begin
                    bp_next = {i_com_wave[1], i_com_wave[1], i_com_wave[0], i_com_wave[0]};
                    en_next = 4'hF;
                end else begin
                    bp_next = {2'h0, i_com_wave[1:0]};
                    en_next = 4'h3;
                end
            end
            LPDC_DUTY_THIRD: begin
                if (i_fill) begin
                    bp_next = {i_nonsel_wave, i_com_wave[2:0]};
                    en_next = 4'hF;
                end else begin
                    bp_next = {1'h0, i_com_wave[2:0]};
                    en_next = 4'h7;
                end
            end
            LPDC_DUTY_QUARTER: begin
                bp_next = i_com_wave;
                en_next = 4'hF;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_backplane <= 4'h0;
            o_backplane_en <= 4'h0;
        end else begin
            o_backplane <= bp_next;
            o_backplane_en <= en_next;
        end
    end

endmodule : lpdc_backplane_map

// ---- src/lpdc_top.sv ----
// Display pin control: APB registers, shared pin multiplexer and backplane routing
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "lpdc_regs.svh"

// Overview of operation
// - Group code converts pin groups from the top, two more per code pair; top bit all.
// - Codes 0000 and 0001 keep every shared pin as port; with expansion, 0000 gives the top four to the expander.
// - Expansion bit puts expander signals on top four pins; group code must be 0000.
// - Two-bit ratio field picks static, half, third or quarter duty drive.
// - Static with fill: backplanes 2 to 4 copy backplane 1; else only 1.
// - Half duty with fill: 4 copies 3, 2 copies 1; else 1 and 2.
// - Third duty with fill: backplane 4 drives non-selected; else only 1 to 3.
module lpdc_top
    import lpdc_pkg::*;
#(
    parameter int PIN_COUNT = 32,
    parameter int GROUP_WIDTH = 4
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [`LPDC_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [PIN_COUNT-1:0] i_pin,
    output logic [PIN_COUNT-1:0] o_pin,
    output logic [PIN_COUNT-1:0] o_pin_oe,
    input wire logic [PIN_COUNT-1:0] i_display_drive_line,
    input wire logic i_ext_latch_clock,
    input wire logic i_ext_shift_clock,
    input wire logic i_ext_serial_data,
    input wire logic i_ext_ac_phase,
    input wire logic [3:0] i_com_wave,
    input wire logic i_nonsel_wave,
    output logic [3:0] o_backplane,
    output logic [3:0] o_backplane_en,
    output logic [1:0] o_multiplex_ratio,
    output logic [`LPDC_GROUP_COUNT-1:0] o_drive_group_mask
);

    localparam int GROUPS = `LPDC_GROUP_COUNT;

    if (PIN_COUNT != GROUPS * GROUP_WIDTH || GROUP_WIDTH < 1) begin : g_bad_size
        $error("Pin count must be eight groups of the group width");
    end

    // Groups counted from the top: group GROUPS-1 holds the highest pins
    function automatic logic [GROUPS-1:0] group_mask(input logic [3:0] code);
        logic [GROUPS-1:0] m;
        m = '0;
        if (code[3]) begin
            m = '1;
        end else begin
            unique case (code[2:1])
                2'h0: m = '0;
                2'h1: m = 8'hC0;
                2'h2: m = 8'hF0;
                2'h3: m = 8'hFC;
            endcase
        end
        return m;
    endfunction : group_mask

    function automatic logic [31:0] read_word(input logic [`LPDC_ADDR_W-1:0] addr,
                                              input logic [7:0] ctrl,
                                              input logic [31:0] data,
                                              input logic [31:0] dir,
                                              input logic [31:0] pins,
                                              input logic [31:0] status);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (addr)
            `LPDC_CTRL_OFS: w = {24'h00_0000, ctrl};
            `LPDC_PORT_DATA_OFS: w = data;
            `LPDC_PORT_DIR_OFS: w = dir;
            `LPDC_PORT_IN_OFS: w = pins;
            `LPDC_STATUS_OFS: w = status;
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction : read_word

    function automatic logic addr_mapped(input logic [`LPDC_ADDR_W-1:0] addr);
        return (addr == `LPDC_CTRL_OFS) || (addr == `LPDC_PORT_DATA_OFS) || (addr == `LPDC_PORT_DIR_OFS) ||
               (addr == `LPDC_PORT_IN_OFS) || (addr == `LPDC_STATUS_OFS);
    endfunction : addr_mapped

    logic [7:0] ctrl_reg;
    logic [PIN_COUNT-1:0] port_data_reg;
    logic [PIN_COUNT-1:0] port_dir_reg;
    logic [PIN_COUNT-1:0] pin_meta_reg;
    logic [PIN_COUNT-1:0] pin_sync_reg;
    logic [31:0] rd_data_reg;
    logic rd_err_reg;
    logic [PIN_COUNT-1:0] pin_out_next;
    logic [PIN_COUNT-1:0] pin_oe_next;
    logic [GROUPS-1:0] mask_next;
    logic [GROUPS-1:0] mask_reg;
    logic illegal_next;
    logic illegal_reg;
    logic expand_next;
    logic expand_reg;
    logic [3:0] group_code;
    logic [31:0] status_word;
    logic wr_en;
    logic setup_phase;
    lpdc_duty_t duty;

    assign group_code = ctrl_reg[`LPDC_GROUP_MSB:`LPDC_GROUP_LSB];
    assign duty = lpdc_duty_t'(ctrl_reg[`LPDC_DUTY_MSB:`LPDC_DUTY_LSB]);
    assign wr_en = i_psel && i_penable && i_pwrite;
    assign setup_phase = i_psel && !i_penable;

    // Control register write
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            ctrl_reg <= `LPDC_CTRL_RST;
        end else if (wr_en && i_paddr == `LPDC_CTRL_OFS) begin
            ctrl_reg <= i_pwdata[7:0];
        end
    end

    // Port data and direction registers
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            port_data_reg <= PIN_COUNT'(`LPDC_PORT_RST);
            port_dir_reg <= PIN_COUNT'(`LPDC_PORT_RST);
        end else if (wr_en) begin
            if (i_paddr == `LPDC_PORT_DATA_OFS) begin
                port_data_reg <= i_pwdata[PIN_COUNT-1:0];
            end
            if (i_paddr == `LPDC_PORT_DIR_OFS) begin
                port_dir_reg <= i_pwdata[PIN_COUNT-1:0];
            end
        end
    end

    // Pin input synchroniser
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= i_pin;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Pin function decode
    always_comb begin
        expand_next = ctrl_reg[`LPDC_EXPAND_BIT];
        illegal_next = expand_next && (group_code != 4'h0);
        mask_next = expand_next ? '0 : group_mask(group_code);
        for (int p = 0; p < PIN_COUNT; p++) begin
            if (mask_next[p / GROUP_WIDTH]) begin
                pin_out_next[p] = i_display_drive_line[p];
                pin_oe_next[p] = 1'b1;
            end else begin
                pin_out_next[p] = port_data_reg[p];
                pin_oe_next[p] = port_dir_reg[p];
            end
        end
        if (expand_next && !illegal_next) begin
            pin_out_next[PIN_COUNT-1] = i_ext_latch_clock;
            pin_out_next[PIN_COUNT-2] = i_ext_shift_clock;
            pin_out_next[PIN_COUNT-3] = i_ext_serial_data;
            pin_out_next[PIN_COUNT-4] = i_ext_ac_phase;
            pin_oe_next[PIN_COUNT-1 -: 4] = 4'hF;
        end
    end

    // Registered pin drive and decode state
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_pin <= '0;
            o_pin_oe <= '0;
            mask_reg <= '0;
            illegal_reg <= 1'b0;
            expand_reg <= 1'b0;
        end else begin
            o_pin <= pin_out_next;
            o_pin_oe <= pin_oe_next;
            mask_reg <= mask_next;
            illegal_reg <= illegal_next;
            expand_reg <= expand_next;
        end
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`LPDC_STAT_ILLEGAL_BIT] = illegal_reg;
        status_word[`LPDC_STAT_EXPAND_BIT] = expand_reg && !illegal_reg;
        status_word[`LPDC_STAT_MASK_LSB +: GROUPS] = mask_reg;
        status_word[`LPDC_STAT_BP_EN_LSB +: 4] = o_backplane_en;
    end

    // Read data captured in the setup phase, zero wait states
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            rd_data_reg <= 32'h0000_0000;
            rd_err_reg <= 1'b0;
        end else if (setup_phase) begin
            rd_data_reg <= i_pwrite ? 32'h0000_0000 :
                read_word(i_paddr, ctrl_reg, 32'(port_data_reg), 32'(port_dir_reg), 32'(pin_sync_reg), status_word);
            rd_err_reg <= !addr_mapped(i_paddr);
        end
    end

    assign o_prdata = rd_data_reg;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && rd_err_reg;
    assign o_multiplex_ratio = ctrl_reg[`LPDC_DUTY_MSB:`LPDC_DUTY_LSB];
    assign o_drive_group_mask = mask_reg;

    lpdc_backplane_map u_backplane_map (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_duty(duty),
        .i_fill(ctrl_reg[`LPDC_FILL_BIT]),
        .i_com_wave(i_com_wave),
        .i_nonsel_wave(i_nonsel_wave),
        .o_backplane(o_backplane),
        .o_backplane_en(o_backplane_en)
    );

endmodule : lpdc_top

// ---- verification/lpdc_glass_model.sv ----
// Glass and expander side: resolves shared pin levels
`timescale 1ns/1ns
module lpdc_glass_model (
    input wire logic i_clk,
    input wire logic [31:0] i_drive,
    input wire logic [31:0] i_drive_oe,
    output logic [31:0] o_level
);
    logic [31:0] last_reg = 32'h0000_0000;
    always_ff @(posedge i_clk) begin
        last_reg <= i_drive;
    end
    // Released pins show the inverse of the last value
    assign o_level = (i_drive & i_drive_oe) | (~last_reg & ~i_drive_oe);
endmodule : lpdc_glass_model

// ---- verification/lpdc_top_checker.sv ----
// Assertions on the display pin control ports
`timescale 1ns/1ns
`include "lpdc_regs.svh"
module lpdc_top_checker #(
    parameter int PIN_COUNT = 32
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [`LPDC_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [PIN_COUNT-1:0] o_pin,
    input wire logic [PIN_COUNT-1:0] o_pin_oe,
    input wire logic [PIN_COUNT-1:0] i_display_drive_line,
    input wire logic [3:0] i_com_wave,
    input wire logic i_nonsel_wave,
    input wire logic [3:0] o_backplane,
    input wire logic [3:0] o_backplane_en,
    input wire logic [1:0] o_multiplex_ratio,
    input wire logic [`LPDC_GROUP_COUNT-1:0] o_drive_group_mask
);
    logic [PIN_COUNT-1:0] drv_bits;
    always_comb begin
        for (int k = 0; k < PIN_COUNT; k++) begin
            drv_bits[k] = o_drive_group_mask[k / 4];
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_ctrl_write;
        i_psel && !i_penable ##1 i_psel && i_penable && i_pwrite && i_paddr == `LPDC_CTRL_OFS;
    endsequence
    a_write_ready: assert property (s_ctrl_write |-> o_pready ##1 o_multiplex_ratio == $past(i_pwdata[7:6]))
        else $error("ctrl write not answered or not stored");
    a_ratio_hold: assert property ($changed(o_multiplex_ratio) |-> $past(i_psel && i_penable && i_pwrite))
        else $error("ratio changed without write");
    a_mask_codes: assert property (o_drive_group_mask inside {8'h00, 8'hC0, 8'hF0, 8'hFC, 8'hFF})
        else $error("group mask not a legal pattern");
    a_drive_pins: assert property (1'b1 |=> ((o_pin_oe & drv_bits) == drv_bits)
        && (((o_pin ^ $past(i_display_drive_line)) & drv_bits) == '0)) else $error("drive pin wrong");
    a_slverr_phase: assert property (o_pslverr |-> i_psel && i_penable)
        else $error("error outside access phase");
    a_static_map: assert property (o_multiplex_ratio == 2'h0 |=>
        (o_backplane_en == 4'hF && o_backplane == {4{$past(i_com_wave[0])}})
        || (o_backplane_en == 4'h1 && o_backplane == {3'h0, $past(i_com_wave[0])})) else $error("static map");
    a_half_map: assert property (o_multiplex_ratio == 2'h1 |=> (o_backplane_en == 4'hF
        && o_backplane == {{2{$past(i_com_wave[1])}}, {2{$past(i_com_wave[0])}}})
        || (o_backplane_en == 4'h3 && o_backplane == {2'h0, $past(i_com_wave[1:0])})) else $error("half map");
    a_third_map: assert property (o_multiplex_ratio == 2'h2 |=> (o_backplane_en == 4'hF
        && o_backplane == {$past(i_nonsel_wave), $past(i_com_wave[2:0])})
        || (o_backplane_en == 4'h7 && o_backplane == {1'b0, $past(i_com_wave[2:0])})) else $error("third map");
    a_quarter_map: assert property (o_multiplex_ratio == 2'h3 |=>
        o_backplane_en == 4'hF && o_backplane == $past(i_com_wave)) else $error("quarter map");
endmodule : lpdc_top_checker

bind lpdc_top lpdc_top_checker #(.PIN_COUNT(PIN_COUNT)) u_lpdc_top_checker (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_pin(o_pin), .o_pin_oe(o_pin_oe), .i_display_drive_line(i_display_drive_line),
    .i_com_wave(i_com_wave), .i_nonsel_wave(i_nonsel_wave), .o_backplane(o_backplane),
    .o_backplane_en(o_backplane_en), .o_multiplex_ratio(o_multiplex_ratio),
    .o_drive_group_mask(o_drive_group_mask));

// ---- verification/test_lcd_port_duty_control.sv ----
// Self-checking bench for the display pin control block
`timescale 1ns/1ns
module test_lcd_port_duty_control;
    logic clk, rst, psel, pen, pwr, pready, pslverr, nonsel, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, pin_in, pin_out, pin_oe, dline, q, pd, pr, ep, eo;
    logic [3:0] ext, com, bp, bp_en, com_q, be;
    logic nonsel_q;
    logic [1:0] ratio;
    logic [7:0] mask, c, em;
    int error_cnt = 0;
    int compares = 0;
    int seed = 32'he99e;
    int tbl[4] = '{0, 'hC0, 'hF0, 'hFC};
    lpdc_top u_lpdc_top (.i_sys_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_pin(pin_in), .o_pin(pin_out), .o_pin_oe(pin_oe),
        .i_display_drive_line(dline), .i_ext_latch_clock(ext[3]), .i_ext_shift_clock(ext[2]),
        .i_ext_serial_data(ext[1]), .i_ext_ac_phase(ext[0]), .i_com_wave(com), .i_nonsel_wave(nonsel),
        .o_backplane(bp), .o_backplane_en(bp_en), .o_multiplex_ratio(ratio), .o_drive_group_mask(mask));
    lpdc_glass_model u_lpdc_glass_model (.i_clk(clk), .i_drive(pin_out), .i_drive_oe(pin_oe), .o_level(pin_in));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Waveforms seen by the design at the last edge, for the backplane model
    always @(posedge clk) begin
        com_q <= com;
        nonsel_q <= nonsel;
        com <= 4'($random(seed));
        nonsel <= 1'($random(seed));
    end
    function automatic logic [3:0] exp_bp(input logic [7:0] cv, input logic [3:0] w, input logic ns);
        logic [3:0] r;
        r = w;
        if (cv[7:6] == 2'h0) begin
            r = cv[5] ? {4{w[0]}} : {3'h0, w[0]};
        end
        if (cv[7:6] == 2'h1) begin
            r = cv[5] ? {w[1], w[1], w[0], w[0]} : {2'h0, w[1:0]};
        end
        if (cv[7:6] == 2'h2) begin
            r = cv[5] ? {ns, w[2:0]} : {1'h0, w[2:0]};
        end
        return r;
    endfunction : exp_bp
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic end_of_test;
        $display("compares=%0d errors=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n == 16) begin
            error_cnt++;
            end_of_test();
        end
    endtask : apb
    initial begin
        {rst, psel, pen, pwr, paddr, pwdata, dline, ext} = '0;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        chk(32'(bp_en), 32'h0000_0001);
        chk(pin_oe, 32'h0000_0000);
        $display("reset test done");
        for (int i = 0; i < 128; i++) begin
            c = {i[6:5], 1'($random(seed)), i[4:0]};
            pd = $random(seed);
            pr = $random(seed);
            dline <= $random(seed);
            ext <= 4'($random(seed));
            apb(1'b1, 12'h004, pd);
            apb(1'b1, 12'h008, pr);
            apb(1'b1, 12'h000, {24'h00_0000, c});
            repeat (2) @(posedge clk);
            em = c[4] ? 8'h00 : (c[3] ? 8'hFF : 8'(tbl[c[2:1]]));
            for (int k = 0; k < 32; k++) begin
                if (em[k / 4]) begin
                    ep[k] = dline[k];
                    eo[k] = 1'b1;
                end else if (c[4] && c[3:0] == 4'h0 && k >= 28) begin
                    ep[k] = ext[k - 28];
                    eo[k] = 1'b1;
                end else begin
                    ep[k] = pd[k];
                    eo[k] = pr[k];
                end
            end
            be = (c[7:6] == 2'h3 || c[5]) ? 4'hF : 4'((2 << c[7:6]) - 1);
            chk(32'(mask), 32'(em));
            chk(pin_oe, eo);
            chk(pin_out, ep);
            chk(32'(bp_en), 32'(be));
            chk(32'(bp), 32'(exp_bp(c, com_q, nonsel_q)));
            chk(32'(ratio), 32'(c[7:6]));
            apb(1'b0, 12'h000, 32'h0000_0000);
            chk(q, {24'h00_0000, c});
            apb(1'b0, 12'h00C, 32'h0000_0000);
            chk(q & eo, ep & eo);
            apb(1'b0, 12'h010, 32'h0000_0000);
            chk(q, {12'h000, be, em, 6'h00, c[4] && c[3:0] == 4'h0, c[4] && c[3:0] != 4'h0});
        end
        $display("sweep test done");
        apb(1'b1, 12'h020, 32'h0000_00FF);
        chk(32'(err), 32'h0000_0001);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(q, {24'h00_0000, c});
        $display("unmapped test done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(32'(bp_en), 32'h0000_0000);
        @(posedge clk);
        chk(32'(bp_en), 32'h0000_0001);
        chk(32'(mask), 32'h0000_0000);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        $display("mid-run reset test done");
        end_of_test();
    end
endmodule : test_lcd_port_duty_control
